// ### rtl/tbid_pkg.sv
/*
 * Shared constants and types of the twelve-bit instruction decoder:
 * register offsets, reset values, field positions, op codes, states.
 * Assumes a 100 MHz core clock and an APB master with 32-bit data.
 */
`default_nettype none
package tbid_pkg;
  // instruction cycle: four core periods
  localparam int PHASES = 4;
  localparam int PH_W = 2;
  // word fields
  localparam int IW_W = 12;
  localparam int DEST_BIT = 5;
  localparam int FILE_LSB = 0;
  localparam int FILE_W = 5;
  localparam int BITN_LSB = 5;
  localparam int LIT_W = 8;
  localparam int PC_W = 9;
  localparam logic [4:0] PCL_ADDR = 5'h02;
  localparam logic [4:0] PORT_ADDR = 5'h06;
  localparam logic [2:0] DIR_SEL = 3'h6;
  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [8:0] PC_RST = 9'h000;
  // APB byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACCUM = 8'h08;
  localparam logic [7:0] OFS_PORTCFG = 8'h0C;
  localparam int CTRL_RUN = 0;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_SEQ = 5;
  localparam int ST_PC = 16;

  typedef enum logic [1:0] {
    SEQ_HALT = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_SLEEP = 2'b11
  } tbid_seq_t;

  typedef enum logic [5:0] {
    OP_IDLE, OP_STORE, OP_CLRACC, OP_CLRFILE, OP_SUB, OP_DEC, OP_OR,
    OP_AND, OP_XOR, OP_ADD, OP_MOVE, OP_CPL, OP_INC, OP_DECSZ, OP_RORC,
    OP_ROLC, OP_SWAP, OP_INCSZ, OP_BITCLR, OP_BITSET, OP_BTSC, OP_BTSS,
    OP_OPTION, OP_SLEEP, OP_WDTCLR, OP_DIRLD, OP_RETLIT, OP_CALL, OP_JUMP,
    OP_LDLIT, OP_ORLIT, OP_ANDLIT, OP_XORLIT
  } tbid_op_t;
endpackage
`default_nettype wire

// ### rtl/tbid_phase_gen.sv
/*
 * Divides the core clock into the four periods of an instruction cycle
 * and gives a one-cycle enable on the last one.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module tbid_phase_gen (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  output logic [tbid_pkg::PH_W-1:0] o_phase,
  output logic o_cycle_end
);
  logic [tbid_pkg::PH_W-1:0] phase_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      phase_q <= '0;
    else
      phase_q <= phase_q + 1'b1;
  end

  assign o_phase = phase_q;
  assign o_cycle_end = (phase_q == tbid_pkg::PH_W'(tbid_pkg::PHASES - 1));

  property p_four_periods;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end;
  endproperty
  a_four_periods: assert property (p_four_periods)
    else $error("instruction cycle is not four periods");
endmodule
`default_nettype wire

// ### rtl/tbid_core.sv
/*
 * Instruction decoder and sequencer of a small 8-bit core: decodes the
 * 12-bit word, drives the file register port, keeps W, flags, program
 * counter, stack, option and direction latches. APB slave for control.
 * Assumes program memory answers i_instr for o_pc within one cycle and
 * the file register port answers i_file_rdata combinationally.
 */
// Local design decisions: the APB register port and the placing of the registers.
`default_nettype none
// How it works
// - byte ops take opcode 11:6, destination bit 5, file address 4:0.
// - destination 0 writes W, destination 1 writes the file register.
// - bit ops take opcode 11:8, bit number 7:5, file address 4:0.
// - literal ops take opcode 11:8 and an 8-bit literal 7:0.
// - pattern 101 in 11:9 branches to 9-bit target, two cycles.
// - one cycle each; true skips and program counter changes take two.
// - an instruction cycle is four core clock periods.
// - logic ops, complement, increment, decrement change only zero flag.
// - move, clear file, clear W set zero; store W and nop change none.
// - add and subtract write destination and update carry, half, zero.
// - increment/decrement-skip write result, keep flags, skip on zero.
// - rotates change only carry; nibble swap changes no flag.
// - bit clear and set force one file bit, flags unchanged.
// - bit tests skip on clear or set bit, no flag change.
// - literal and/or/xor set zero; load literal changes no flag.
// - call and return take two cycles; return loads literal into W.
// - watchdog clear and standby set timeout/powerdown; option load.
// - call and low-byte program counter writes clear bit 8.
// - reading the port register as source uses pin levels.
// - direction load with field 6 copies W to direction latches.
// - a taken skip turns the fetched next word into a nop.
module tbid_core #(
  parameter int STACK_DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [8:0] o_pc,
  input wire logic [11:0] i_instr,
  output logic [4:0] o_file_addr,
  input wire logic [7:0] i_file_rdata,
  output logic [7:0] o_file_wdata,
  output logic o_file_we,
  input wire logic [7:0] i_pin_level,
  output logic [7:0] o_dir_latch,
  output logic [7:0] o_option,
  output logic o_wdt_clear,
  input wire logic i_wake
);
  if (STACK_DEPTH < 1 || STACK_DEPTH > 8)
  begin : g_chk
    $error("STACK_DEPTH must be 1 to 8");
  end

  function automatic tbid_pkg::tbid_op_t dec_op(input logic [11:0] iw);
    tbid_pkg::tbid_op_t op;
    op = tbid_pkg::OP_IDLE;
    casez (iw)
      12'b0000_0000_0000: op = tbid_pkg::OP_IDLE;
      12'b0000_0000_0010: op = tbid_pkg::OP_OPTION;
      12'b0000_0000_0011: op = tbid_pkg::OP_SLEEP;
      12'b0000_0000_0100: op = tbid_pkg::OP_WDTCLR;
      12'b0000_0000_0???: op = tbid_pkg::OP_DIRLD;
      12'b0000_0100_0000: op = tbid_pkg::OP_CLRACC;
      12'b0000_001?_????: op = tbid_pkg::OP_STORE;
      12'b0000_011?_????: op = tbid_pkg::OP_CLRFILE;
      12'b0000_10??_????: op = tbid_pkg::OP_SUB;
      12'b0000_11??_????: op = tbid_pkg::OP_DEC;
      12'b0001_00??_????: op = tbid_pkg::OP_OR;
      12'b0001_01??_????: op = tbid_pkg::OP_AND;
      12'b0001_10??_????: op = tbid_pkg::OP_XOR;
      12'b0001_11??_????: op = tbid_pkg::OP_ADD;
      12'b0010_00??_????: op = tbid_pkg::OP_MOVE;
      12'b0010_01??_????: op = tbid_pkg::OP_CPL;
      12'b0010_10??_????: op = tbid_pkg::OP_INC;
      12'b0010_11??_????: op = tbid_pkg::OP_DECSZ;
      12'b0011_00??_????: op = tbid_pkg::OP_RORC;
      12'b0011_01??_????: op = tbid_pkg::OP_ROLC;
      12'b0011_10??_????: op = tbid_pkg::OP_SWAP;
      12'b0011_11??_????: op = tbid_pkg::OP_INCSZ;
      12'b0100_????_????: op = tbid_pkg::OP_BITCLR;
      12'b0101_????_????: op = tbid_pkg::OP_BITSET;
      12'b0110_????_????: op = tbid_pkg::OP_BTSC;
      12'b0111_????_????: op = tbid_pkg::OP_BTSS;
      12'b1000_????_????: op = tbid_pkg::OP_RETLIT;
      12'b1001_????_????: op = tbid_pkg::OP_CALL;
      12'b101?_????_????: op = tbid_pkg::OP_JUMP;
      12'b1100_????_????: op = tbid_pkg::OP_LDLIT;
      12'b1101_????_????: op = tbid_pkg::OP_ORLIT;
      12'b1110_????_????: op = tbid_pkg::OP_ANDLIT;
      12'b1111_????_????: op = tbid_pkg::OP_XORLIT;
      default: op = tbid_pkg::OP_IDLE;
    endcase
    return op;
  endfunction

  logic tick;
  tbid_phase_gen u_phase (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_phase(),
    .o_cycle_end(tick)
  );

  tbid_pkg::tbid_seq_t seq_q;
  logic run_q, flush_q, cyc_end;
  logic [11:0] exe_q;
  logic [8:0] pc_q;
  logic [7:0] w_q, opt_q, dir_q;
  logic c_q, dc_q, z_q, to_q, pd_q, wdt_q;
  logic [8:0] stack_q [STACK_DEPTH];
  tbid_pkg::tbid_op_t op;

  assign cyc_end = tick && (seq_q == tbid_pkg::SEQ_RUN);
  // a flushed slot runs as nop so the skip costs one full cycle
  assign op = flush_q ? tbid_pkg::OP_IDLE : dec_op(exe_q);

  // operand fields
  logic dest_f;
  logic [2:0] bitn;
  logic [7:0] lit, fsrc;
  assign dest_f = exe_q[tbid_pkg::DEST_BIT];
  assign bitn = exe_q[tbid_pkg::BITN_LSB +: 3];
  assign lit = exe_q[tbid_pkg::LIT_W-1:0];
  assign o_file_addr = exe_q[tbid_pkg::FILE_LSB +: tbid_pkg::FILE_W];
  // read-modify-write of the port sees the pins, not the output latch
  assign fsrc = (o_file_addr == tbid_pkg::PORT_ADDR) ? i_pin_level
                : i_file_rdata;

  // datapath
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] nib;
  logic res_c, res_dc, to_w, to_f, upd_z, upd_c, upd_dc, skip, pcl;
  always_comb
  begin
    res = 8'h00;
    sum = 9'h000;
    nib = 5'h00;
    res_c = c_q;
    res_dc = dc_q;
    to_w = 1'b0;
    to_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    case (op)
      tbid_pkg::OP_ADD, tbid_pkg::OP_SUB:
      begin
        if (op == tbid_pkg::OP_ADD)
        begin
          sum = {1'b0, fsrc} + {1'b0, w_q};
          nib = {1'b0, fsrc[3:0]} + {1'b0, w_q[3:0]};
        end
        else
        begin
          // carry and half carry mean no borrow
          sum = {1'b0, fsrc} + {1'b0, ~w_q} + 9'h001;
          nib = {1'b0, fsrc[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
        end
        res = sum[7:0];
        res_c = sum[8];
        res_dc = nib[4];
        {upd_c, upd_dc, upd_z} = 3'b111;
      end
      tbid_pkg::OP_AND: {res, upd_z} = {w_q & fsrc, 1'b1};
      tbid_pkg::OP_OR: {res, upd_z} = {w_q | fsrc, 1'b1};
      tbid_pkg::OP_XOR: {res, upd_z} = {w_q ^ fsrc, 1'b1};
      tbid_pkg::OP_CPL: {res, upd_z} = {~fsrc, 1'b1};
      tbid_pkg::OP_INC: {res, upd_z} = {fsrc + 8'h01, 1'b1};
      tbid_pkg::OP_DEC: {res, upd_z} = {fsrc - 8'h01, 1'b1};
      tbid_pkg::OP_MOVE: {res, upd_z} = {fsrc, 1'b1};
      tbid_pkg::OP_INCSZ, tbid_pkg::OP_DECSZ:
      begin
        res = (op == tbid_pkg::OP_INCSZ) ? fsrc + 8'h01 : fsrc - 8'h01;
        skip = (res == 8'h00);
      end
      tbid_pkg::OP_ROLC:
      begin
        {res_c, res} = {fsrc, c_q};
        upd_c = 1'b1;
      end
      tbid_pkg::OP_RORC:
      begin
        {res, res_c} = {c_q, fsrc};
        upd_c = 1'b1;
      end
      tbid_pkg::OP_SWAP: res = {fsrc[3:0], fsrc[7:4]};
      tbid_pkg::OP_BTSC: skip = !fsrc[bitn];
      tbid_pkg::OP_BTSS: skip = fsrc[bitn];
      default: res = 8'h00;
    endcase
    case (op)
      tbid_pkg::OP_ADD, tbid_pkg::OP_SUB, tbid_pkg::OP_AND,
      tbid_pkg::OP_OR, tbid_pkg::OP_XOR, tbid_pkg::OP_CPL,
      tbid_pkg::OP_INC, tbid_pkg::OP_DEC, tbid_pkg::OP_MOVE,
      tbid_pkg::OP_INCSZ, tbid_pkg::OP_DECSZ, tbid_pkg::OP_ROLC,
      tbid_pkg::OP_RORC, tbid_pkg::OP_SWAP:
      begin
        to_w = !dest_f;
        to_f = dest_f;
      end
      default: to_w = 1'b0;
    endcase
  end

  // file register write data and strobe
  always_comb
  begin
    o_file_wdata = res;
    o_file_we = 1'b0;
    case (op)
      tbid_pkg::OP_STORE: {o_file_wdata, o_file_we} = {w_q, 1'b1};
      tbid_pkg::OP_CLRFILE: {o_file_wdata, o_file_we} = {8'h00, 1'b1};
      tbid_pkg::OP_BITCLR:
      begin
        o_file_wdata = fsrc & ~(8'h01 << bitn);
        o_file_we = 1'b1;
      end
      tbid_pkg::OP_BITSET:
      begin
        o_file_wdata = fsrc | (8'h01 << bitn);
        o_file_we = 1'b1;
      end
      default: o_file_we = to_f;
    endcase
    o_file_we = o_file_we && cyc_end;
  end

  // any write of the low counter byte is a counter change
  assign pcl = o_file_we && (o_file_addr == tbid_pkg::PCL_ADDR);

  // sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      seq_q <= tbid_pkg::SEQ_HALT;
    else
      case (seq_q)
        tbid_pkg::SEQ_HALT:
          if (run_q && tick)
            seq_q <= tbid_pkg::SEQ_RUN;
        tbid_pkg::SEQ_RUN:
          if (!run_q && tick)
            seq_q <= tbid_pkg::SEQ_HALT;
          else if (cyc_end && op == tbid_pkg::OP_SLEEP)
            seq_q <= tbid_pkg::SEQ_SLEEP;
        tbid_pkg::SEQ_SLEEP:
          if (i_wake && tick)
            seq_q <= tbid_pkg::SEQ_RUN;
        default: seq_q <= tbid_pkg::SEQ_HALT;
      endcase
  end

  // fetch, program counter, flush
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pc_q <= tbid_pkg::PC_RST;
      exe_q <= 12'h000;
      flush_q <= 1'b1;
    end
    else if (cyc_end)
    begin
      exe_q <= i_instr;
      flush_q <= skip || pcl || op == tbid_pkg::OP_JUMP
                 || op == tbid_pkg::OP_CALL
                 || op == tbid_pkg::OP_RETLIT;
      if (op == tbid_pkg::OP_JUMP)
        pc_q <= exe_q[8:0];
      else if (op == tbid_pkg::OP_CALL)
        pc_q <= {1'b0, lit};
      else if (op == tbid_pkg::OP_RETLIT)
        pc_q <= stack_q[0];
      else if (pcl)
        pc_q <= {1'b0, o_file_wdata};
      else
        pc_q <= pc_q + 9'h001;
    end
  end
  assign o_pc = pc_q;

  // hardware stack, shifts on push and pop
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_q[i] <= 9'h000;
    end
    else if (cyc_end && op == tbid_pkg::OP_CALL)
    begin
      stack_q[0] <= pc_q;
      for (int i = 1; i < STACK_DEPTH; i++)
        stack_q[i] <= stack_q[i-1];
    end
    else if (cyc_end && op == tbid_pkg::OP_RETLIT)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stack_q[i] <= stack_q[i+1];
    end
  end

  // working register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      w_q <= 8'h00;
    else if (cyc_end)
      case (op)
        tbid_pkg::OP_CLRACC: w_q <= 8'h00;
        tbid_pkg::OP_LDLIT, tbid_pkg::OP_RETLIT: w_q <= lit;
        tbid_pkg::OP_ANDLIT: w_q <= w_q & lit;
        tbid_pkg::OP_ORLIT: w_q <= w_q | lit;
        tbid_pkg::OP_XORLIT: w_q <= w_q ^ lit;
        default:
          if (to_w)
            w_q <= res;
      endcase
  end

  // arithmetic flags
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      {c_q, dc_q, z_q} <= 3'b000;
    else if (cyc_end)
    begin
      if (upd_c)
        c_q <= res_c;
      if (upd_dc)
        dc_q <= res_dc;
      case (op)
        tbid_pkg::OP_CLRACC, tbid_pkg::OP_CLRFILE: z_q <= 1'b1;
        tbid_pkg::OP_ANDLIT: z_q <= (w_q & lit) == 8'h00;
        tbid_pkg::OP_ORLIT: z_q <= (w_q | lit) == 8'h00;
        tbid_pkg::OP_XORLIT: z_q <= (w_q ^ lit) == 8'h00;
        default:
          if (upd_z)
            z_q <= (res == 8'h00);
      endcase
    end
  end

  // timeout, powerdown, watchdog clear, option and direction latches
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      {to_q, pd_q, wdt_q} <= 3'b110;
      opt_q <= tbid_pkg::OPTION_RST;
      dir_q <= tbid_pkg::DIR_RST;
    end
    else
    begin
      wdt_q <= cyc_end && (op == tbid_pkg::OP_WDTCLR
                           || op == tbid_pkg::OP_SLEEP);
      if (cyc_end && op == tbid_pkg::OP_WDTCLR)
        {to_q, pd_q} <= 2'b11;
      if (cyc_end && op == tbid_pkg::OP_SLEEP)
        {to_q, pd_q} <= 2'b10;
      if (cyc_end && op == tbid_pkg::OP_OPTION)
        opt_q <= w_q;
      // a 1 leaves the pin floating
      if (cyc_end && op == tbid_pkg::OP_DIRLD
          && exe_q[2:0] == tbid_pkg::DIR_SEL)
        dir_q <= w_q;
    end
  end
  assign o_wdt_clear = wdt_q;
  assign o_option = opt_q;
  assign o_dir_latch = dir_q;

  // APB slave: read data captured in setup, zero-wait access
  logic sel_ok;
  assign sel_ok = paddr == tbid_pkg::OFS_CTRL || paddr == tbid_pkg::OFS_STATUS
                  || paddr == tbid_pkg::OFS_ACCUM
                  || paddr == tbid_pkg::OFS_PORTCFG;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      run_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == tbid_pkg::OFS_CTRL)
      run_q <= pwdata[tbid_pkg::CTRL_RUN];
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      case (paddr)
        tbid_pkg::OFS_CTRL: prdata <= {31'h0, run_q};
        tbid_pkg::OFS_STATUS:
          prdata <= {7'h00, pc_q, 9'h000, seq_q, to_q, pd_q, z_q, dc_q, c_q};
        tbid_pkg::OFS_ACCUM: prdata <= {24'h00_0000, w_q};
        tbid_pkg::OFS_PORTCFG: prdata <= {16'h0000, opt_q, dir_q};
        default: prdata <= 32'h0000_0000;
      endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !sel_ok;

  // checks
  sequence s_exec(tbid_pkg::tbid_op_t o);
    cyc_end && op == o;
  endsequence
  property p_branch_absolute_target;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_JUMP) |=> pc_q == $past(exe_q[8:0]) && flush_q;
  endproperty
  a_branch_absolute_target: assert property (p_branch_absolute_target)
    else $error("absolute branch target or flush wrong");
  property p_call_bit8;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_CALL) |=> !pc_q[8] && stack_q[0] == $past(pc_q);
  endproperty
  a_call_bit8: assert property (p_call_bit8)
    else $error("call did not clear bit 8 or push return");
  property p_skip_flush;
    @(posedge i_clk) disable iff (i_sys_rst)
      cyc_end && skip |=> flush_q ##3 (cyc_end && op == tbid_pkg::OP_IDLE);
  endproperty
  a_skip_flush: assert property (p_skip_flush)
    else $error("taken skip did not discard next word");
  property p_return_with_literal_w;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_RETLIT) |=> w_q == $past(lit) && $stable(z_q);
  endproperty
  a_return_with_literal_w: assert property (p_return_with_literal_w)
    else $error("return literal not in W");
  property p_dest_w;
    @(posedge i_clk) disable iff (i_sys_rst)
      cyc_end && to_w |-> !o_file_we ##1 w_q == $past(res);
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("destination W wrote the file or missed W");
  property p_zero_only;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_AND) or s_exec(tbid_pkg::OP_CPL)
      |=> $stable(c_q) && $stable(dc_q) && z_q == ($past(res) == 8'h00);
  endproperty
  a_zero_only: assert property (p_zero_only)
    else $error("zero-only op disturbed carry");
  property p_bit_set;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_BITSET) |-> o_file_we && o_file_wdata[bitn];
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("bit set did not set the bit");
  property p_dir_load;
    @(posedge i_clk) disable iff (i_sys_rst)
      cyc_end && op == tbid_pkg::OP_DIRLD && exe_q[2:0] == tbid_pkg::DIR_SEL
      |=> o_dir_latch == $past(w_q);
  endproperty
  a_dir_load: assert property (p_dir_load)
    else $error("direction latch not loaded from W");
  property p_nop_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_exec(tbid_pkg::OP_IDLE) |-> !o_file_we ##1 $stable(w_q) && !flush_q;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("nop changed state");
endmodule
`default_nettype wire

// ### verification/tbid_prog_mem.sv
/*
 * Program memory model for the decoder: six words of image, the last
 * a branch to itself, answered combinationally from the fetch address.
 * Assumes the bench changes the image only while the core is in reset.
 */
`default_nettype none
module tbid_prog_mem (
  input wire logic [71:0] i_image,
  input wire logic [8:0] i_pc,
  output logic [11:0] o_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  // fetches past the image read as no-operation words
  always_comb
  begin
    if (i_pc < 9'h006)
    begin
      o_instr = i_image[71 - 12 * int'(i_pc) -: 12];
    end
    else
    begin
      o_instr = 12'h000;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
/*
 * Self-checking bench of the decoder core: table rows of short programs
 * with expected accumulator, flags and file byte, then hand-made cases.
 * Assumes the program memory model and a bench-held file register array.
 */
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, frd, fwd, dir, opt;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] pc;
  logic [11:0] instr;
  logic [4:0] faddr;
  logic fwe, wdtc, wake, err;
  logic [71:0] image;
  logic [7:0] fmem [32];
  int miscompares, checked, cycles, wdt_n, n;
  // program words, accumulator, flag mask, flags, file byte 8
  logic [71:0] rows [31] = '{
    72'hC05_1C8_000_000_14_7_2_0F, 72'hC05_088_000_000_0A_7_3_0F,
    72'hC05_1E8_000_000_05_7_2_14, 72'hC05_148_000_000_05_4_0_0F,
    72'hC05_108_000_000_0F_4_0_0F, 72'hC0F_188_000_000_00_4_4_0F,
    72'hC05_248_000_000_F0_4_0_0F, 72'hC05_288_000_000_10_4_0_0F,
    72'hC05_0C8_000_000_0E_4_0_0F, 72'h040_208_000_000_0F_4_0_0F,
    72'hC05_040_000_000_00_4_4_0F, 72'hC05_068_000_000_05_4_4_00,
    72'h040_C05_028_000_05_4_4_05, 72'h040_388_000_000_F0_4_4_0F,
    72'hC05_088_348_000_1F_5_0_0F, 72'hC05_088_308_000_87_5_1_0F,
    72'h040_5E8_000_000_00_4_4_8F, 72'h040_408_000_000_00_4_4_0E,
    72'h040_708_C33_000_00_4_4_0F, 72'h040_608_C33_000_33_4_4_0F,
    72'h040_688_C33_000_00_4_4_0F, 72'h068_2E8_3C8_C33_00_4_4_FF,
    72'h068_3E8_2C8_C33_00_4_4_01, 72'hC0F_E0C_000_000_0C_4_0_0F,
    72'h040_D30_000_000_30_4_0_0F, 72'hC05_F05_000_000_00_4_4_0F,
    72'h040_C77_000_000_77_4_4_0F, 72'h040_C11_001_000_11_4_4_0F,
    72'h040_A03_C33_C44_44_4_4_0F, 72'h040_903_A05_811_11_4_4_0F,
    72'h040_206_000_000_A5_4_0_0F};

  tbid_core uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_pc(pc),
    .i_instr(instr), .o_file_addr(faddr), .i_file_rdata(frd),
    .o_file_wdata(fwd), .o_file_we(fwe), .i_pin_level(8'hA5),
    .o_dir_latch(dir), .o_option(opt), .o_wdt_clear(wdtc),
    .i_wake(wake));
  tbid_prog_mem mem (.i_image(image), .i_pc(pc), .o_instr(instr));

  assign frd = fmem[faddr];
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (fwe === 1'b1)
      fmem[faddr] <= fwd;
    if (wdtc === 1'b1)
      wdt_n++;
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // setup cycle, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1)
      @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [47:0] p);
    image = {p, 12'h000, 12'hA05};
    i_sys_rst <= 1'b1;
    wdt_n = 0;
    foreach (fmem[i])
      fmem[i] = 8'h00;
    fmem[8] = 8'h0F;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    apb(1'b1, tbid_pkg::OFS_CTRL, 32'h0000_0001);
  endtask

  // the self-branch at word 5 marks the end; four more cycles settle it
  task automatic fin();
    while (pc !== 9'h005)
      @(posedge i_clk);
    repeat (16) @(posedge i_clk);
  endtask

  initial
  begin
    {psel, penable, pwrite, wake, err} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    image = 72'h0;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    `CHK("dir", tbid_pkg::DIR_RST, dir)
    `CHK("option", tbid_pkg::OPTION_RST, opt)
    `CHK("pc", tbid_pkg::PC_RST, pc)
    foreach (rows[i])
    begin
      run(rows[i][71:24]);
      fin();
      apb(1'b0, tbid_pkg::OFS_ACCUM, 32'h0);
      `CHK("accum", rows[i][23:16], rd[7:0])
      apb(1'b0, tbid_pkg::OFS_STATUS, 32'h0);
      `CHK("flags", rows[i][11:8], {1'b0, rd[2:0]} & rows[i][15:12])
      `CHK("file", rows[i][7:0], fmem[8])
    end
    run(48'h0);
    while (pc !== 9'h001)
      @(posedge i_clk);
    n = 0;
    while (pc === 9'h001)
    begin
      n++;
      @(posedge i_clk);
    end
    `CHK("period", 4, n)
    run(48'hC5A_002_C3C_006);
    fin();
    `CHK("option", 8'h5A, opt)
    `CHK("dir", 8'h3C, dir)
    apb(1'b0, tbid_pkg::OFS_PORTCFG, 32'h0);
    `CHK("portcfg", 16'h5A3C, rd[15:0])
    run(48'hC42_004_000_000);
    fin();
    apb(1'b0, tbid_pkg::OFS_STATUS, 32'h0);
    `CHK("to_pd", 2'b11, rd[4:3])
    `CHK("wdt", 1, wdt_n)
    apb(1'b1, tbid_pkg::OFS_ACCUM, 32'h0000_0099);
    apb(1'b0, tbid_pkg::OFS_ACCUM, 32'h0);
    `CHK("ro accum", 8'h42, rd[7:0])
    apb(1'b0, 8'h10, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    run(48'h003_C66_000_000);
    while (wdt_n == 0)
      @(posedge i_clk);
    repeat (16) @(posedge i_clk);
    apb(1'b0, tbid_pkg::OFS_STATUS, 32'h0);
    `CHK("standby", 4'b1110, rd[6:3])
    wake <= 1'b1;
    fin();
    wake <= 1'b0;
    apb(1'b0, tbid_pkg::OFS_ACCUM, 32'h0);
    `CHK("wake", 8'h66, rd[7:0])
    print_verdict();
  end
endmodule
`default_nettype wire
